// ### hw/adcrs_pkg.sv
// constants, types and tick functions of the reading-mode sequencer
// Overview of operation
// - with chip select held low, result bits leave MSB first on serial clock rises.
// - reading period is fixed overhead plus channel wait plus conversion time.
// - in loop modes only the first reading pays the two-tick overhead.
// - six-bit wait code 17 gives a wait of 76 system ticks.
// - five-bit rate code 5 gives 24000 samples per second, 384 ticks.
// - settling select 0 runs single-cycle settling conversions.
// - all delays count 9.216 MHz system ticks.
// - trigger select 0 starts on command, 1 starts on trigger pin rise.
// - single channel loop mode repeats until end, abort or restart.
// - a new start event aborts and restarts an ongoing loop reading.
// - multichannel modes visit enabled channels in ascending order.
// - one-pass multichannel mode returns idle after the last enabled channel.
// - multichannel loop mode restarts from the first enabled channel until end or abort.
// - a restart during multichannel modes begins again at the first channel.
// - mask bit i enables channel i using table entry i.
// - result is readable once data ready rises; host fetches only then.
// - status read clears the interrupt output.
// - end stops after the current conversion, abort stops at once.
package adcrs_pkg;
    localparam int unsigned CLOCK_HZ   = 250000000;
    localparam int unsigned SYS_CLK_HZ = 9216000;
    localparam int ACC_W  = 29;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SYS_CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLOCK_HZ);

    localparam int CNT_W  = 20;
    localparam int WORD_W = 24;
    localparam int CHAN_N = 16;
    localparam int CHAN_W = 4;
    localparam int WAIT_W = 6;
    localparam int RATE_W = 5;

    localparam logic [CNT_W-1:0]  FIXED_TICKS     = 20'h00002;
    localparam logic [CNT_W-1:0]  WAIT_BASE_TICKS = 20'h00008;
    localparam int                WAIT_STEP_SHIFT = 2;
    localparam logic [CNT_W-1:0]  CONV_BASE_TICKS = 20'h0000c;
    localparam logic [RATE_W-1:0] RATE_CODE_MAX   = 5'h0d;
    localparam int                SETTLE_SHIFT    = 2;

    localparam logic [WAIT_W-1:0] WAIT_REF_CODE  = 6'h11;
    localparam logic [CNT_W-1:0]  WAIT_REF_TICKS = 20'h0004c;
    localparam logic [RATE_W-1:0] RATE_REF_CODE  = 5'h05;
    localparam logic [CNT_W-1:0]  RATE_REF_TICKS = 20'h00180;

    localparam logic DATA_READY_PIN_RESET = 1'b0;
    localparam logic IRQ_N_RESET = 1'b1;

    typedef enum logic [1:0] {
        one_chan_one_shot_mode,
        one_chan_loop_mode,
        multi_chan_one_pass_mode,
        multi_chan_loop_mode
    } adcrs_mode_t;

    typedef enum logic [1:0] {st_idle, st_fixed, st_wait, st_conv} adcrs_state_t;

    function automatic logic [CNT_W-1:0] wait_ticks(
        input logic [WAIT_W-1:0] code);
        return WAIT_BASE_TICKS + (CNT_W'(code) << WAIT_STEP_SHIFT);
    endfunction

    function automatic logic [CNT_W-1:0] conv_ticks(
        input logic [RATE_W-1:0] code, input logic normal);
        logic [RATE_W-1:0] c;
        logic [CNT_W-1:0]  t;
        c = (code > RATE_CODE_MAX) ? RATE_CODE_MAX : code;
        t = CONV_BASE_TICKS << c;
        if (normal) begin
            t = t << SETTLE_SHIFT;
        end
        return t;
    endfunction
endpackage

// ### hw/adcrs_link_if.sv
// interface carrying the result word to the link side and read status back from it
`timescale 1ns/100ps
`default_nettype none
interface adcrs_link_if #(parameter int WORD_W = adcrs_pkg::WORD_W);
    logic [WORD_W-1:0] word;
    logic              read_done;
    modport seq (output word, input read_done);
    modport shf (input word, output read_done);
endinterface
`default_nettype wire

// ### hw/adcrs_shifter.sv
// serial result shifter running on the host's serial clock
`timescale 1ns/100ps
`default_nettype none
module adcrs_shifter #(
    parameter int WORD_W = adcrs_pkg::WORD_W
) (
    input  wire logic  sclk,
    input  wire logic  chip_select_n,
    output var  logic  serial_data_out,
    adcrs_link_if.shf  lnk
);
    localparam int BIT_W = $clog2(WORD_W + 1);

    logic [WORD_W-1:0] shift_q;
    logic [BIT_W-1:0]  bit_q;
    logic              read_done_q;

    assign lnk.read_done = read_done_q;

    // =====================================================================
    // frame shifter
    // sclk stops between frames, so chip select high clears the frame
    // word is stable here: it only changes at a conversion end, on the
    // same clock edge that data ready rises again
    always_ff @(posedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            shift_q         <= '0;
            bit_q           <= '0;
            serial_data_out <= 1'b0;
            read_done_q     <= 1'b0;
        end else begin
            if (bit_q == '0) begin
                serial_data_out <= lnk.word[WORD_W-1];
                shift_q         <= lnk.word << 1;
            end else begin
                serial_data_out <= shift_q[WORD_W-1];
                shift_q         <= shift_q << 1;
            end
            if (bit_q != BIT_W'(WORD_W)) begin
                bit_q <= bit_q + 1'b1;
            end
            if (bit_q == BIT_W'(WORD_W - 1)) begin
                read_done_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/adcrs_sequencer.sv
// reading-mode conversion sequencer top
`timescale 1ns/100ps
`default_nettype none
module adcrs_sequencer #(
    parameter int WORD_W = adcrs_pkg::WORD_W,
    parameter int CHAN_N = adcrs_pkg::CHAN_N,
    parameter int CHAN_W = adcrs_pkg::CHAN_W
) (
    input  wire logic                            clock,
    input  wire logic                            srst,
    input  wire logic                            clk_en,
    input  wire logic                            sclk,
    input  wire logic                            chip_select_n,
    output var  logic                            serial_data_out,
    input  wire logic                            trigger_pin,
    input  wire logic                            trigger_select,
    input  wire logic                            settling_mode_select,
    input  wire logic [CHAN_N-1:0]               channel_enable_mask,
    input  wire logic                            channel_select_cmd,
    input  wire logic [CHAN_W-1:0]               channel_select_index,
    input  wire logic                            cfg_wr,
    input  wire logic [CHAN_W-1:0]               cfg_index,
    input  wire logic [adcrs_pkg::WAIT_W-1:0]    channel_wait_code,
    input  wire logic [adcrs_pkg::RATE_W-1:0]    output_data_rate,
    input  wire logic                            one_shot_cmd,
    input  wire logic                            single_chan_continuous_cmd,
    input  wire logic                            multi_chan_multiread_cmd,
    input  wire logic                            multi_chan_continuous_cmd,
    input  wire logic                            end_cmd,
    input  wire logic                            abort_cmd,
    input  wire logic                            status_read,
    input  wire logic [WORD_W-1:0]               adc_sample,
    output var  logic                            data_ready_pin,
    output var  logic                            interrupt_out_n,
    output var  logic                            reading_active,
    output var  logic [CHAN_W-1:0]               active_chan
);
    localparam int CW = adcrs_pkg::CNT_W;

    // =====================================================================
    // trigger pin synchroniser and edge detect
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;
    logic trig_rise;

    always_ff @(posedge clock) begin
        if (srst) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else if (clk_en) begin
            trig_s1_q <= trigger_pin;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end
    assign trig_rise = trig_s2_q & ~trig_s3_q;

    // =====================================================================
    // system tick: 9.216 MHz from the fast clock by phase accumulation
    logic [adcrs_pkg::ACC_W-1:0] acc_q;
    logic [adcrs_pkg::ACC_W-1:0] acc_sum;
    logic                        tick_q;

    assign acc_sum = acc_q + adcrs_pkg::ACC_STEP;

    always_ff @(posedge clock) begin
        if (srst) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            if (acc_sum >= adcrs_pkg::ACC_WRAP) begin
                acc_q  <= acc_sum - adcrs_pkg::ACC_WRAP;
                tick_q <= 1'b1;
            end else begin
                acc_q  <= acc_sum;
                tick_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // per-channel configuration table
    logic [adcrs_pkg::WAIT_W-1:0] wait_tab_q [CHAN_N];
    logic [adcrs_pkg::RATE_W-1:0] rate_tab_q [CHAN_N];

    for (genvar i = 0; i < CHAN_N; i++) begin : g_tab
        always_ff @(posedge clock) begin
            if (srst) begin
                wait_tab_q[i] <= '0;
                rate_tab_q[i] <= '0;
            end else if (clk_en && cfg_wr && cfg_index == CHAN_W'(i)) begin
                wait_tab_q[i] <= channel_wait_code;
                rate_tab_q[i] <= output_data_rate;
            end
        end
    end

    // =====================================================================
    // command decode and start event
    adcrs_pkg::adcrs_mode_t mode_q;
    adcrs_pkg::adcrs_mode_t cmd_mode;
    adcrs_pkg::adcrs_mode_t go_mode;
    logic [CHAN_W-1:0]      sel_chan_q;
    logic                   cmd_any;
    logic                   go_take;
    logic                   go_multi;

    always_comb begin
        cmd_mode = adcrs_pkg::one_chan_one_shot_mode;
        if (single_chan_continuous_cmd) begin
            cmd_mode = adcrs_pkg::one_chan_loop_mode;
        end else if (multi_chan_multiread_cmd) begin
            cmd_mode = adcrs_pkg::multi_chan_one_pass_mode;
        end else if (multi_chan_continuous_cmd) begin
            cmd_mode = adcrs_pkg::multi_chan_loop_mode;
        end
    end

    assign cmd_any = one_shot_cmd | single_chan_continuous_cmd
                   | multi_chan_multiread_cmd | multi_chan_continuous_cmd;

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q     <= adcrs_pkg::one_chan_one_shot_mode;
            sel_chan_q <= '0;
        end else if (clk_en) begin
            if (cmd_any) begin
                mode_q <= cmd_mode;
            end
            if (channel_select_cmd) begin
                sel_chan_q <= channel_select_index;
            end
        end
    end

    // first enabled channel at or above a start index
    function automatic logic [CHAN_W:0] next_en(
        input logic [CHAN_N-1:0] m, input logic [CHAN_W:0] from);
        logic [CHAN_W:0] r;
        r = '0;
        for (int i = CHAN_N - 1; i >= 0; i--) begin
            if (m[i] && i >= int'(from)) begin
                r = {1'b1, CHAN_W'(i)};
            end
        end
        return r;
    endfunction

    logic [CHAN_W:0] first_en;
    logic [CHAN_W:0] after_en;
    logic            go_ok;
    logic            go_raw;
    logic [CHAN_W:0] chan_next_idx;

    assign first_en = next_en(channel_enable_mask, '0);
    assign go_mode  = trigger_select ? mode_q : cmd_mode;
    assign go_raw   = trigger_select ? trig_rise : cmd_any;
    assign go_multi = (go_mode == adcrs_pkg::multi_chan_one_pass_mode)
                   || (go_mode == adcrs_pkg::multi_chan_loop_mode);
    assign go_ok    = !go_multi || first_en[CHAN_W];
    assign go_take  = go_raw && go_ok;

    // =====================================================================
    // reading sequencer
    adcrs_pkg::adcrs_state_t state_q;
    adcrs_pkg::adcrs_mode_t  run_mode_q;
    logic [CW-1:0]           cnt_q;
    logic [CHAN_W-1:0]       chan_q;
    logic                    stop_q;
    logic                    cnt_end;
    logic                    conv_done;
    logic                    wait_done;
    logic                    nxt_ok;
    logic [CHAN_W-1:0]       nxt_chan;
    logic                    last_conv;

    assign chan_next_idx = {1'b0, chan_q} + 1'b1;
    assign after_en  = next_en(channel_enable_mask, chan_next_idx);
    assign cnt_end   = tick_q && cnt_q == CW'(1);
    assign conv_done = state_q == adcrs_pkg::st_conv && cnt_end;
    assign wait_done = state_q == adcrs_pkg::st_wait && cnt_end;

    // what follows a finished conversion
    always_comb begin
        nxt_ok   = 1'b0;
        nxt_chan = chan_q;
        if (stop_q || end_cmd
            || run_mode_q == adcrs_pkg::one_chan_one_shot_mode) begin
            nxt_ok = 1'b0;
        end else if (run_mode_q == adcrs_pkg::one_chan_loop_mode) begin
            nxt_ok = 1'b1;
        end else if (after_en[CHAN_W]) begin
            nxt_ok   = 1'b1;
            nxt_chan = after_en[CHAN_W-1:0];
        end else if (run_mode_q == adcrs_pkg::multi_chan_loop_mode
                     && first_en[CHAN_W]) begin
            nxt_ok   = 1'b1;
            nxt_chan = first_en[CHAN_W-1:0];
        end
    end
    assign last_conv = conv_done && !nxt_ok;

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q    <= adcrs_pkg::st_idle;
            run_mode_q <= adcrs_pkg::one_chan_one_shot_mode;
            cnt_q      <= '0;
            chan_q     <= '0;
            stop_q     <= 1'b0;
        end else if (clk_en) begin
            if (abort_cmd) begin
                state_q <= adcrs_pkg::st_idle;
                stop_q  <= 1'b0;
            end else begin
                if (end_cmd && state_q != adcrs_pkg::st_idle) begin
                    stop_q <= 1'b1;
                end
                if (tick_q && cnt_q != '0) begin
                    cnt_q <= cnt_q - 1'b1;
                end
                if (go_take) begin
                    // a start aborts any reading in flight
                    state_q    <= adcrs_pkg::st_fixed;
                    cnt_q      <= adcrs_pkg::FIXED_TICKS;
                    run_mode_q <= go_mode;
                    chan_q     <= go_multi ? first_en[CHAN_W-1:0]
                                           : sel_chan_q;
                    stop_q     <= 1'b0;
                end else begin
                    unique case (state_q)
                        adcrs_pkg::st_idle: begin
                            stop_q <= 1'b0;
                        end
                        adcrs_pkg::st_fixed: begin
                            if (cnt_end) begin
                                state_q <= adcrs_pkg::st_wait;
                                cnt_q   <= adcrs_pkg::wait_ticks(
                                    wait_tab_q[chan_q]);
                            end
                        end
                        adcrs_pkg::st_wait: begin
                            if (cnt_end) begin
                                state_q <= adcrs_pkg::st_conv;
                                cnt_q   <= adcrs_pkg::conv_ticks(
                                    rate_tab_q[chan_q],
                                    settling_mode_select);
                            end
                        end
                        adcrs_pkg::st_conv: begin
                            if (conv_done && nxt_ok) begin
                                // loop readings skip the fixed overhead
                                state_q <= adcrs_pkg::st_wait;
                                chan_q  <= nxt_chan;
                                cnt_q   <= adcrs_pkg::wait_ticks(
                                    wait_tab_q[nxt_chan]);
                            end else if (conv_done) begin
                                state_q <= adcrs_pkg::st_idle;
                                stop_q  <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // =====================================================================
    // result capture and crossing to the serial clock domain
    logic [WORD_W-1:0] result_q;
    logic              rd_s1_q;
    logic              rd_s2_q;
    logic              rd_s3_q;
    logic              read_pulse;

    adcrs_link_if #(.WORD_W(WORD_W)) lnk ();
    assign lnk.word = result_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            result_q <= '0;
        end else if (clk_en && conv_done && !abort_cmd) begin
            result_q <= adc_sample;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_s1_q <= 1'b0;
            rd_s2_q <= 1'b0;
            rd_s3_q <= 1'b0;
        end else if (clk_en) begin
            rd_s1_q <= lnk.read_done;
            rd_s2_q <= rd_s1_q;
            rd_s3_q <= rd_s2_q;
        end
    end
    assign read_pulse = rd_s2_q & ~rd_s3_q;

    adcrs_shifter #(.WORD_W(WORD_W)) u_shifter (
        .sclk            (sclk),
        .chip_select_n   (chip_select_n),
        .serial_data_out (serial_data_out),
        .lnk             (lnk)
    );

    // =====================================================================
    // data ready, interrupt and status pins
    always_ff @(posedge clock) begin
        if (srst) begin
            data_ready_pin <= adcrs_pkg::DATA_READY_PIN_RESET;
        end else if (clk_en) begin
            if (conv_done && !abort_cmd) begin
                data_ready_pin <= 1'b1;
            end else if ((wait_done && !abort_cmd && !go_take)
                         || read_pulse) begin
                data_ready_pin <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            interrupt_out_n <= adcrs_pkg::IRQ_N_RESET;
        end else if (clk_en) begin
            if (last_conv && !abort_cmd && !go_take) begin
                interrupt_out_n <= 1'b0;
            end else if (status_read) begin
                interrupt_out_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reading_active <= 1'b0;
            active_chan    <= '0;
        end else if (clk_en) begin
            reading_active <= state_q != adcrs_pkg::st_idle;
            active_chan    <= chan_q;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    logic calm;
    assign calm = clk_en && !abort_cmd && !go_take;

    sequence s_start;
        clk_en && !abort_cmd && go_take;
    endsequence

    sequence s_conv_begin;
        calm && wait_done;
    endsequence

    a_start_overhead: assert property (
        s_start |=> state_q == adcrs_pkg::st_fixed
                    && cnt_q == adcrs_pkg::FIXED_TICKS)
        else $error("start did not enter fixed overhead");

    a_loop_no_fixed: assert property (
        calm && conv_done && nxt_ok |=> state_q == adcrs_pkg::st_wait)
        else $error("loop reading paid fixed overhead");

    a_wait_code_ref: assert property (
        calm && state_q == adcrs_pkg::st_fixed && cnt_end
        && wait_tab_q[chan_q] == adcrs_pkg::WAIT_REF_CODE
        |=> cnt_q == adcrs_pkg::WAIT_REF_TICKS)
        else $error("wait code did not load its tick count");

    a_rate_code_ref: assert property (
        s_conv_begin ##0 (rate_tab_q[chan_q] == adcrs_pkg::RATE_REF_CODE
        && !settling_mode_select)
        |=> cnt_q == adcrs_pkg::RATE_REF_TICKS)
        else $error("rate code did not load its conversion ticks");

    a_trig_ignored: assert property (
        clk_en && !abort_cmd && !trigger_select && !cmd_any
        && state_q == adcrs_pkg::st_idle |=> state_q == adcrs_pkg::st_idle)
        else $error("sequencer left idle without a command");

    a_abort_now: assert property (
        clk_en && abort_cmd |=> state_q == adcrs_pkg::st_idle)
        else $error("abort did not stop at once");

    a_end_defers: assert property (
        calm && end_cmd && state_q == adcrs_pkg::st_conv && !conv_done
        |=> state_q == adcrs_pkg::st_conv)
        else $error("end stopped before conversion finished");

    a_pass_ends: assert property (
        calm && conv_done && !after_en[CHAN_W]
        && run_mode_q == adcrs_pkg::multi_chan_one_pass_mode
        |=> state_q == adcrs_pkg::st_idle)
        else $error("one pass did not return idle");

    a_data_ready_pin_sets: assert property (
        clk_en && !abort_cmd && conv_done |=> data_ready_pin)
        else $error("data ready missing after conversion");

    a_data_ready_pin_drops: assert property (
        s_conv_begin ##0 !read_pulse |=> !data_ready_pin)
        else $error("data ready held into next conversion");

    a_irq_clear: assert property (
        clk_en && status_read && !last_conv |=> interrupt_out_n)
        else $error("status read did not clear interrupt");
endmodule
`default_nettype wire

// ### verif/adcrs_host_model.sv
// host side serial reader: clock runs only inside a frame
`timescale 1ns/100ps
`default_nettype none
module adcrs_host_model (
    output var  logic sclk,
    output var  logic chip_select_n,
    input  wire logic serial_data_out
);
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
    end
    // one frame of 24 rises at a 160 ns period, bit taken mid high phase
    task automatic read_word(output logic [23:0] w);
        chip_select_n = 1'b0;
        #80;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b1;
            #40;
            w[i] = serial_data_out;
            #40;
            sclk = 1'b0;
            #80;
        end
        chip_select_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### verif/adcrs_sequencer_tb.sv
// self-checking bench for the reading-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module adcrs_sequencer_tb;
    localparam logic [23:0] SAMPLE = 24'h5a3c96;
    logic        clock = 1'b0, srst = 1'b1, trig = 1'b0, tsel = 1'b0;
    logic        sclk, csn, sdo, ready, irq_n, act, cfg_wr = 1'b0, sel = 1'b0;
    logic [15:0] mask = 16'h0000;
    logic [6:0]  cmd = 7'h00;
    logic [3:0]  idx = 4'h0, chan;
    logic [5:0]  wc = 6'h00;
    logic [4:0]  rate = 5'h00;
    logic [23:0] w;
    logic        settle = 1'b0, en = 1'b1;
    logic [3:0]  seq[$];
    int          errors = 0, compares = 0, n, m;
    always #2 clock = ~clock;
    adcrs_host_model host_u (.sclk(sclk), .chip_select_n(csn),
        .serial_data_out(sdo));
    adcrs_sequencer dut_u (.clock(clock), .srst(srst), .clk_en(en),
        .sclk(sclk), .chip_select_n(csn), .serial_data_out(sdo),
        .trigger_pin(trig), .trigger_select(tsel),
        .settling_mode_select(settle), .channel_enable_mask(mask),
        .channel_select_cmd(sel), .channel_select_index(idx),
        .cfg_wr(cfg_wr), .cfg_index(idx), .channel_wait_code(wc),
        .output_data_rate(rate), .one_shot_cmd(cmd[0]),
        .single_chan_continuous_cmd(cmd[1]),
        .multi_chan_multiread_cmd(cmd[2]),
        .multi_chan_continuous_cmd(cmd[3]), .end_cmd(cmd[4]),
        .abort_cmd(cmd[5]), .status_read(cmd[6]), .adc_sample(SAMPLE),
        .data_ready_pin(ready), .interrupt_out_n(irq_n),
        .reading_active(act), .active_chan(chan));
    // channel visiting order, one entry per change while reading
    always @(posedge clock) begin
        if (act === 1'b1 && (seq.size() == 0 || seq[$] !== chan)) begin
            seq.push_back(chan);
        end
    end
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // s: 0 ready level, 1 active level, 2 visit count reached
    task automatic wait_for(input int s, input int v, input int lim,
                            output int k);
        k = 0;
        while (!(s == 2 ? seq.size() >= v : (s ? act : ready) === v[0])) begin
            @(posedge clock);
            k++;
            if (k > lim) begin
                errors++;
                give_verdict();
            end
        end
    endtask
    task automatic pulse(input int b);
        cmd <= 7'h01 << b;
        @(posedge clock);
        cmd <= 7'h00;
        @(posedge clock);
    endtask
    task automatic cfg(input int i, input logic [5:0] c, input logic [4:0] r);
        idx <= 4'(i);
        wc <= c;
        rate <= r;
        cfg_wr <= 1'b1;
        @(posedge clock);
        cfg_wr <= 1'b0;
        @(posedge clock);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (int i = 1; i < 16; i++) cfg(i, 6'h00, 5'h00);
        cfg(0, 6'h11, 5'h05);
        pulse(0);
        wait_for(0, 1, 20000, n);
        check(24'(n >= 12497 && n <= 12568), 24'h1);
        repeat (3) @(posedge clock);
        check(24'(irq_n), 24'h0);
        host_u.read_word(w);
        check(w, SAMPLE);
        repeat (6) @(posedge clock);
        check(24'(ready), 24'h0);
        pulse(6);
        repeat (2) @(posedge clock);
        check(24'(irq_n), 24'h1);
        $display("test one shot done");
        cfg(0, 6'h00, 5'h00);
        mask <= 16'h1111;
        seq.delete();
        pulse(2);
        wait_for(1, 1, 20, n);
        wait_for(1, 0, 5000, n);
        for (int i = 0; i < 4; i++) check(24'(seq[i]), 24'(4 * i));
        check(24'(seq.size()), 24'h4);
        check(24'(irq_n), 24'h0);
        pulse(6);
        $display("test one pass done");
        mask <= 16'h1001;
        seq.delete();
        pulse(3);
        wait_for(2, 2, 5000, n);
        pulse(3);
        repeat (4) @(posedge clock);
        check(24'(chan), 24'h0);
        wait_for(2, 5, 5000, n);
        check(24'(seq[4]), 24'h0);
        pulse(5);
        repeat (3) @(posedge clock);
        check(24'(act), 24'h0);
        $display("test loop done");
        pulse(1);
        wait_for(0, 0, 5000, n);
        wait_for(0, 1, 5000, n);
        wait_for(0, 0, 5000, n);
        wait_for(0, 1, 5000, m);
        check(24'(n + m >= 515 && n + m <= 570), 24'h1);
        pulse(4);
        wait_for(0, 0, 5000, n);
        wait_for(0, 1, 5000, n);
        wait_for(1, 0, 10, n);
        check(24'(n > 0), 24'h1);
        $display("test continuous done");
        tsel <= 1'b1;
        pulse(0);
        repeat (40) @(posedge clock);
        check(24'(act), 24'h0);
        trig <= 1'b1;
        repeat (60) @(posedge clock);
        trig <= 1'b0;
        check(24'(act), 24'h1);
        pulse(5);
        $display("test trigger done");
        tsel <= 1'b0;
        settle <= 1'b1;
        idx <= 4'h5;
        sel <= 1'b1;
        @(posedge clock);
        sel <= 1'b0;
        pulse(0);
        wait_for(0, 0, 5000, n);
        check(24'(chan), 24'h5);
        // freeze for 100 cycles mid conversion: the count must not move
        en <= 1'b0;
        repeat (100) @(posedge clock);
        en <= 1'b1;
        wait_for(0, 1, 5000, n);
        check(24'(n >= 1290 && n <= 1315), 24'h1);
        $display("test settling done");
        give_verdict();
    end
endmodule
`default_nettype wire
